// File: inc/hpc_pkg.sv
// Summary of operation
// - Fast input means slot is PCI-X capable.
// - Top-speed input low 66 MHz, high 133.
// - Bus starts conventional 33 MHz before scan.
// - Slot one used for codes 1111, 1001, 1010.
// - Slot two used only for code 1010.
// - Two presence inputs give presence and power.
package hpc_pkg;

    localparam logic [3:0]  CFG_ONE_NO_GLUE = 4'hF;
    localparam logic [3:0]  CFG_SINGLE_PAR  = 4'h9;
    localparam logic [3:0]  CFG_DUAL_PAR    = 4'hA;

    localparam int          SYNC_W      = 12;
    localparam logic [11:0] SYNC_INIT   = 12'hCC0;
    localparam int          IN_CODE_LO  = 0;
    localparam int          IN_S1_LO    = 4;
    localparam int          IN_S2_LO    = 8;
    localparam int          PIN_FAST    = 0;
    localparam int          PIN_TOP     = 1;
    localparam int          PIN_PA      = 2;
    localparam int          PIN_PB      = 3;

    localparam logic [31:0] ADDR_STATUS  = 32'h0000_0000;
    localparam logic [31:0] ADDR_CONTROL = 32'h0000_0004;
    localparam logic [31:0] ADDR_CONFIG  = 32'h0000_0008;

    localparam int          ST_SLOT1_LO  = 0;
    localparam int          ST_SLOT2_LO  = 8;
    localparam int          ST_MODE_LO   = 16;
    localparam int          ST_MHZ_LO    = 24;
    localparam int          CT_MODE_LO   = 0;
    localparam int          CT_APPLY_BIT = 8;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Bus rates in MHz: 33, 66 and 133.
    localparam logic [7:0]  MHZ_CONV     = 8'h21;
    localparam logic [7:0]  MHZ_PCIX66   = 8'h42;
    localparam logic [7:0]  MHZ_PCIX133  = 8'h85;

    typedef enum logic [1:0] {
        HPC_CONV33,
        HPC_PCIX66,
        HPC_PCIX133
    } hpc_mode_t;

    typedef struct packed {
        logic       valid;
        logic       present;
        logic [1:0] power_class;
        logic       top_speed;
        logic       fast_capable;
    } hpc_slot_caps_t;

endpackage : hpc_pkg

// File: design/hpc_sync.sv
`timescale 1ns/10ps
module hpc_sync #(
    parameter int                WIDTH = 1,
    parameter logic [WIDTH-1:0]  INIT  = '0
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] stable_out
);
    import hpc_pkg::*;

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    wire  [WIDTH-1:0] agree = ~(s2 ^ s3);
    wire  [WIDTH-1:0] next_stable = (agree & s2) | (~agree & stable_out);

    // A bit moves only once the second and third stages agree, so a
    // glitch shorter than a clock never reaches firmware.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1         <= INIT;
            s2         <= INIT;
            s3         <= INIT;
            stable_out <= INIT;
        end else begin
            s1         <= raw_in;
            s2         <= s1;
            s3         <= s2;
            stable_out <= next_stable;
        end
    end

    chk_sync_agree: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (stable_out != $past(stable_out)) |->
            (($past(s2) ^ $past(s3)) & (stable_out ^ $past(stable_out)))
            == '0)
        else $error("synchroniser output moved without agreement");

endmodule : hpc_sync

// File: design/hpc_slot_caps.sv
`timescale 1ns/10ps
module hpc_slot_caps (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [3:0]             slot_config_code,
    input  wire logic                   slot1_fast_capable_in,
    input  wire logic                   slot1_top_speed_in,
    input  wire logic                   slot1_presence_a_n,
    input  wire logic                   slot1_presence_b_n,
    input  wire logic                   slot2_fast_capable_in,
    input  wire logic                   slot2_top_speed_in,
    input  wire logic                   slot2_presence_a_n,
    input  wire logic                   slot2_presence_b_n,
    output hpc_pkg::hpc_slot_caps_t     slot1_caps,
    output hpc_pkg::hpc_slot_caps_t     slot2_caps,
    output hpc_pkg::hpc_mode_t          bus_mode,
    output logic                        bus_reset_pulse,
    input  wire logic [31:0]            awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [31:0]            araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready
);
    import hpc_pkg::*;

    logic [SYNC_W-1:0] sync_q;
    wire  [SYNC_W-1:0] raw_pins = {slot2_presence_b_n, slot2_presence_a_n,
                                   slot2_top_speed_in, slot2_fast_capable_in,
                                   slot1_presence_b_n, slot1_presence_a_n,
                                   slot1_top_speed_in, slot1_fast_capable_in,
                                   slot_config_code};

    hpc_sync #(
        .WIDTH (SYNC_W),
        .INIT  (SYNC_INIT)
    ) u_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .raw_in     (raw_pins),
        .stable_out (sync_q)
    );

    wire [3:0] code = sync_q[IN_CODE_LO +: 4];
    wire [3:0] s1   = sync_q[IN_S1_LO +: 4];
    wire [3:0] s2   = sync_q[IN_S2_LO +: 4];

    wire slot1_en = (code == CFG_ONE_NO_GLUE) || (code == CFG_SINGLE_PAR)
                 || (code == CFG_DUAL_PAR);
    wire slot2_en = (code == CFG_DUAL_PAR);

    // A card is in when either presence contact is pulled low; the pair,
    // inverted, is the card's power class code.
    wire s1_in = ~(s1[PIN_PA] & s1[PIN_PB]);
    wire s2_in = ~(s2[PIN_PA] & s2[PIN_PB]);

    hpc_slot_caps_t next_slot1;
    hpc_slot_caps_t next_slot2;
    assign next_slot1 = {slot1_en, slot1_en & s1_in,
                         {2{slot1_en}} & ~{s1[PIN_PB], s1[PIN_PA]},
                         slot1_en & s1[PIN_TOP],
                         slot1_en & s1[PIN_FAST]};
    assign next_slot2 = {slot2_en, slot2_en & s2_in,
                         {2{slot2_en}} & ~{s2[PIN_PB], s2[PIN_PA]},
                         slot2_en & s2[PIN_TOP],
                         slot2_en & s2[PIN_FAST]};

    // A faster mode is granted only if every installed, enabled card
    // supports it; an empty bus stays conventional.
    wire any_in  = slot1_caps.present | slot2_caps.present;
    wire fast_ok = any_in
                 & (~slot1_caps.present | slot1_caps.fast_capable)
                 & (~slot2_caps.present | slot2_caps.fast_capable);
    wire top_ok  = fast_ok
                 & (~slot1_caps.present | slot1_caps.top_speed)
                 & (~slot2_caps.present | slot2_caps.top_speed);

    hpc_mode_t mode_req;
    hpc_mode_t granted;

    logic [7:0] bus_mhz;
    always_comb begin
        case (bus_mode)
            HPC_PCIX66:  bus_mhz = MHZ_PCIX66;
            HPC_PCIX133: bus_mhz = MHZ_PCIX133;
            default:     bus_mhz = MHZ_CONV;
        endcase
    end

    // Write channel: address and data are held apart until both are in.
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    assign awready = ~aw_held & ~bvalid;
    assign wready  = ~w_held & ~bvalid;
    assign arready = ~rvalid;

    wire do_write  = aw_held & w_held & ~bvalid;
    wire wr_mapped = (aw_addr == ADDR_STATUS) || (aw_addr == ADDR_CONTROL)
                  || (aw_addr == ADDR_CONFIG);
    wire wr_ctrl   = do_write & (aw_addr == ADDR_CONTROL);
    wire set_mode  = wr_ctrl & w_strb[0];
    wire apply     = wr_ctrl & w_strb[1] & w_data[CT_APPLY_BIT];

    // A request written in the same word as the apply bit takes effect at
    // once; code 3 names no mode and so grants the conventional bus.
    wire [1:0] req_bits = set_mode ? w_data[CT_MODE_LO +: 2] : mode_req;
    assign granted = (req_bits == HPC_PCIX133 && top_ok) ? HPC_PCIX133 :
                     ((req_bits == HPC_PCIX66 || req_bits == HPC_PCIX133)
                      && fast_ok) ? HPC_PCIX66 : HPC_CONV33;

    wire [31:0] st_word = {bus_mhz, 6'h00, bus_mode,
                           2'h0, slot2_caps, 2'h0, slot1_caps};
    wire [31:0] ct_word = {30'h0, mode_req};
    wire [31:0] cf_word = {28'h000_0000, code};
    wire [31:0] ar_addr = {araddr[31:2], 2'b00};
    wire        rd_map  = (ar_addr == ADDR_STATUS)
                       || (ar_addr == ADDR_CONTROL)
                       || (ar_addr == ADDR_CONFIG);
    wire [31:0] rd_word = (ar_addr == ADDR_STATUS)  ? st_word :
                          (ar_addr == ADDR_CONTROL) ? ct_word :
                          (ar_addr == ADDR_CONFIG)  ? cf_word : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot1_caps <= '0;
            slot2_caps <= '0;
        end else begin
            slot1_caps <= next_slot1;
            slot2_caps <= next_slot2;
        end
    end

    // The bus only changes mode at a firmware-ordered reset, never while
    // cards are running; system reset leaves it conventional, a bus reset leaves it in the granted mode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_req        <= HPC_CONV33;
            bus_mode        <= HPC_CONV33;
            bus_reset_pulse <= 1'b0;
        end else begin
            if (set_mode) begin
                mode_req <= hpc_mode_t'(w_data[CT_MODE_LO +: 2]);
            end
            if (apply) begin
                bus_mode <= granted;
            end
            bus_reset_pulse <= apply;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= {awaddr[31:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_slot1_code_gate: assert property (
        slot1_caps.valid |-> ($past(code) == CFG_ONE_NO_GLUE
            || $past(code) == CFG_SINGLE_PAR || $past(code) == CFG_DUAL_PAR))
        else $error("slot one captured under a foreign code");

    chk_slot2_code_gate: assert property (
        (slot2_caps != '0) |-> $past(code) == CFG_DUAL_PAR)
        else $error("slot two captured outside dual-slot code");

    chk_fast_capture: assert property (
        slot1_caps.fast_capable |-> $past(s1[PIN_FAST]) && slot1_caps.valid)
        else $error("fast capability without its input");

    chk_top_grant: assert property (
        (bus_mode == HPC_PCIX133 && $past(bus_mode) != HPC_PCIX133)
            |-> $past(top_ok) && $past(apply))
        else $error("133 MHz mode granted without capability");

    chk_mode_change: assert property (
        (bus_mode != $past(bus_mode)) |-> $past(apply) && bus_reset_pulse)
        else $error("bus mode changed without a bus reset");

    chk_presence_class: assert property (
        slot2_caps.present |-> slot2_caps.power_class != 2'b00)
        else $error("card present with an empty power class");

    chk_write_resp: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before acceptance");

    chk_read_resp: assert property (
        arvalid && arready |=> rvalid ##0 (rvalid && !rready)[*1]
            or (rvalid && rready))
        else $error("read answer missing one cycle after address");

endmodule : hpc_slot_caps

// File: bench/hpc_card_model.sv
`timescale 1ns/10ps
module hpc_card_model (
    input  wire logic [1:0] cap_level,
    input  wire logic [1:0] contact_n,
    output logic            fast_capable,
    output logic            top_speed,
    output logic            presence_a_n,
    output logic            presence_b_n
);
    // Level 0 is a grounded pin, 1 the low level and 2 the high level.
    assign fast_capable = (cap_level != 2'h0);
    assign top_speed    = (cap_level == 2'h2);
    // No glue on the contacts, so an empty slot reads high on both.
    assign presence_a_n = contact_n[0];
    assign presence_b_n = contact_n[1];
endmodule : hpc_card_model

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import hpc_pkg::*;
    logic           aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]     slot_config_code, wstrb;
    logic [31:0]    awaddr, wdata, araddr;
    logic [1:0]     lvl1, lvl2, prs1, prs2, req;
    wire            slot1_fast_capable_in, slot1_top_speed_in;
    wire            slot1_presence_a_n, slot1_presence_b_n;
    wire            slot2_fast_capable_in, slot2_top_speed_in;
    wire            slot2_presence_a_n, slot2_presence_b_n;
    wire            awready, wready, bvalid, arready, rvalid;
    wire [1:0]      bresp, rresp;
    wire [31:0]     rdata;
    hpc_slot_caps_t slot1_caps, slot2_caps;
    hpc_slot_caps_t e [2];
    hpc_mode_t      bus_mode;
    logic           bus_reset_pulse;
    logic [1:0]     emode;
    logic [34:0]    rq [$];
    logic [1:0]     bq [$];
    int             err_total, comparisons, pulses, n;

    hpc_card_model card1 (.cap_level(lvl1), .contact_n(prs1),
        .fast_capable(slot1_fast_capable_in), .top_speed(slot1_top_speed_in),
        .presence_a_n(slot1_presence_a_n), .presence_b_n(slot1_presence_b_n));
    hpc_card_model card2 (.cap_level(lvl2), .contact_n(prs2),
        .fast_capable(slot2_fast_capable_in), .top_speed(slot2_top_speed_in),
        .presence_a_n(slot2_presence_a_n), .presence_b_n(slot2_presence_b_n));
    hpc_slot_caps uut (.aclk, .aresetn, .slot_config_code,
        .slot1_fast_capable_in, .slot1_top_speed_in, .slot1_presence_a_n,
        .slot1_presence_b_n, .slot2_fast_capable_in, .slot2_top_speed_in,
        .slot2_presence_a_n, .slot2_presence_b_n, .slot1_caps, .slot2_caps,
        .bus_mode, .bus_reset_pulse, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    initial aclk = 1'b0;
    always #5 aclk = ~aclk;

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    task automatic test_done();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    // Error reads carry no defined data, so bit 34 says whether to compare it.
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (rq[0][34]) chk({rresp, rdata}, rq[0][33:0]);
            else chk({32'h0, rresp}, {32'h0, rq[0][33:32]});
            void'(rq.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1) chk({32'h0, bresp},
            {32'h0, bq.pop_front()});
        if (bus_reset_pulse === 1'b1) pulses++;
    end

    task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
        logic aw_ok, w_ok;
        bq.push_back(er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) awvalid <= 1'b0;
            if (!w_ok && wready === 1'b1) wvalid <= 1'b0;
            aw_ok = aw_ok || awready === 1'b1;
            w_ok = w_ok || wready === 1'b1;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, input logic dchk,
                          input logic [1:0] er, input logic [31:0] ed);
        rq.push_back({dchk, er, ed});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    function automatic hpc_slot_caps_t exp_caps(input logic en,
                                                input logic [1:0] lv, pr);
        hpc_slot_caps_t c;
        c = '0;
        c.valid = en;
        c.present = en && !(&pr);
        c.power_class = en ? ~pr : 2'h0;
        c.top_speed = en && lv == 2'h2;
        c.fast_capable = en && lv != 2'h0;
        return c;
    endfunction : exp_caps

    // An empty system keeps the conventional mode whatever was asked.
    function automatic logic [1:0] grant(input logic [1:0] r);
        logic [1:0] g, c;
        logic       any;
        g = (r == 2'h3) ? 2'h0 : r;
        any = 1'b0;
        for (int k = 0; k < 2; k++) begin
            c = e[k].fast_capable ? (e[k].top_speed ? 2'h2 : 2'h1) : 2'h0;
            any = any | e[k].present;
            if (e[k].present && c < g) g = c;
        end
        return any ? g : 2'h0;
    endfunction : grant

    task automatic rd_status();
        logic [7:0] mhz;
        mhz = emode == 2'h2 ? MHZ_PCIX133 : emode == 2'h1 ? MHZ_PCIX66 :
            MHZ_CONV;
        axi_rd(ADDR_STATUS, 1'b1, RESP_OKAY,
            {mhz, 6'h0, emode, 2'h0, e[1], 2'h0, e[0]});
    endtask : rd_status

    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        test_done();
    end

    initial begin
        void'($urandom(24827));
        {aresetn, awvalid, wvalid, bready, arvalid, rready} <= '0;
        {awaddr, wdata, araddr, lvl1, lvl2, req} <= '0;
        slot_config_code <= 4'h0;
        wstrb <= 4'hF;
        prs1 <= 2'h3;
        prs2 <= 2'h3;
        emode = 2'h0;
        e[0] = '0;
        e[1] = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({28'h0, slot1_caps}, 34'h0);
        chk({32'h0, bus_mode}, {32'h0, HPC_CONV33});
        rd_status();
        for (int i = 0; i < 12; i++) begin
            if (i % 4 == 0) slot_config_code <= CFG_ONE_NO_GLUE;
            if (i % 4 == 1) slot_config_code <= CFG_SINGLE_PAR;
            if (i % 4 == 2) slot_config_code <= CFG_DUAL_PAR;
            if (i % 4 == 3) slot_config_code <= 4'(i % 9); // unused codes 3, 7 and 2
            lvl1 <= 2'($urandom % 3);
            lvl2 <= 2'($urandom % 3);
            prs1 <= 2'($urandom);
            prs2 <= 2'($urandom);
            repeat (7) @(posedge aclk);
            e[0] = exp_caps(slot_config_code inside {CFG_ONE_NO_GLUE,
                CFG_SINGLE_PAR, CFG_DUAL_PAR}, lvl1, prs1);
            e[1] = exp_caps(slot_config_code == CFG_DUAL_PAR, lvl2, prs2);
            chk({28'h0, slot1_caps}, {28'h0, e[0]});
            chk({28'h0, slot2_caps}, {28'h0, e[1]});
            rd_status();
            axi_rd(ADDR_CONFIG, 1'b1, RESP_OKAY, {28'h0, slot_config_code});
            req = 2'($urandom);
            n = pulses;
            axi_wr(ADDR_CONTROL, {23'h0, 1'b1, 6'h0, req}, RESP_OKAY);
            emode = grant(req);
            repeat (2) @(posedge aclk);
            chk({32'h0, bus_mode}, {32'h0, emode});
            chk(34'(pulses - n), 34'h1);
            axi_rd(ADDR_CONTROL, 1'b1, RESP_OKAY, {30'h0, req});
        end
        axi_rd(32'h0000_0010, 1'b0, RESP_SLVERR, 32'h0);
        axi_wr(32'h0000_000C, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_wr(ADDR_STATUS, 32'h0, RESP_OKAY);
        rd_status();
        repeat (4) @(posedge aclk);
        test_done();
    end
endmodule : testbench
